// ===== bench/flash_device_model.sv
// Behavioural boot-block flash device on the far side of the host controller.
// Assumes registered strobes from the host, sampled on clock_in.
`timescale 1ns/1ps
module flash_device_model
  import flash_host_pkg::*;
#(parameter int AW = 20, parameter int DW = 16, parameter int ERR_BIT = 4,
  parameter int BUSY_CYCLES = 6, parameter int BOOT_WORDS = 8192,
  parameter int BLOCK_WORDS = 32768,
  parameter logic [15:0] MAKER_CODE = 16'h005a, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h00c3 // Arbitrary value
) (
  input  wire logic          clock_in,
  input  wire logic          ce_n_in,
  input  wire logic          we_n_in,
  input  wire logic          oe_n_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          drive_in,
  input  wire logic          write_protect_n_in,
  input  wire logic          reset_powerdown_pin_n_in,
  input  wire logic          high_voltage_in,
  output logic      [DW-1:0] data_out
);
  // ****************************************
  // Device state
  // ****************************************
  logic [DW-1:0] mem [int];
  logic [1:0]    mode;
  logic [1:0]    pend;
  logic [DW-1:0] status;
  int            busy;
  logic          suspended;
  logic          we_q = 1'b1;
  logic [DW-1:0] last_q = '0;
  logic [DW-1:0] rd;
  int            a;
  wire           unlocked = write_protect_n_in | high_voltage_in;

  function automatic logic [DW-1:0] rd_mem(int k);
    return mem.exists(k) ? mem[k] : '1;
  endfunction

  function automatic int blk(int k);
    return (k < BOOT_WORDS) ? -1 : k / BLOCK_WORDS;
  endfunction

  // Command decode on rising write strobe; reset pin overrides decode and busy count, not last_q capture
  always @(posedge clock_in) begin
    a = int'(addr_in);
    we_q <= we_n_in;
    if (!reset_powerdown_pin_n_in) begin
      status    <= 16'h0080;
      mode      <= 2'd0;
      pend      <= 2'd0;
      busy      <= 0;
      suspended <= 1'b0;
    end else begin
      if (busy > 0 && !suspended) begin
        busy <= busy - 1;
        if (busy == 1) status[READY_BIT] <= 1'b1;
      end
      if (!we_q && we_n_in && !ce_n_in && drive_in) begin
        if (pend != 2'd0) begin
          pend <= 2'd0;
          mode <= 2'd2;
          if (pend == 2'd2 && data_in[7:0] != CMD_CONFIRM) begin
            // Broken erase pair leaves array untouched
          end else if (blk(a) < 0 && !unlocked) begin
            status[ERR_BIT] <= 1'b1;
          end else begin
            status[READY_BIT] <= 1'b0;
            busy <= BUSY_CYCLES;
            if (pend == 2'd1) begin
              mem[a] = rd_mem(a) & data_in;
            end else begin
              foreach (mem[k]) if (blk(k) == blk(a)) mem[k] = '0;
              foreach (mem[k]) if (blk(k) == blk(a)) mem[k] = '1;
            end
          end
        end else begin
          case (data_in[7:0])
            CMD_READ_ARRAY:   mode <= 2'd0;
            CMD_IDENTIFY:     mode <= 2'd1;
            CMD_READ_STATUS:  mode <= 2'd2;
            CMD_CLEAR_STATUS: status[ERR_BIT] <= 1'b0;
            CMD_ERASE_SETUP:  pend <= 2'd2;
            CMD_PROG_SETUP,
            CMD_ALT_PROG:     pend <= 2'd1;
            CMD_SUSPEND: begin
              suspended <= 1'b1;
              mode      <= 2'd2;
            end
            CMD_CONFIRM:      suspended <= 1'b0;
            default: ;
          endcase
        end
      end
    end
    if (!ce_n_in && !oe_n_in) last_q <= rd;
  end

  // Read mux; released bus shows inverse of last value, not a stale copy
  always @* begin
    if (mode == 2'd0) rd = rd_mem(int'(addr_in));
    else if (mode == 2'd1) rd = (addr_in == AW'(ID_MAKER_LOC)) ? MAKER_CODE :
                                (addr_in == AW'(ID_DEVICE_LOC)) ? DEVICE_CODE : '0;
    else rd = status;
  end
  assign data_out = (!ce_n_in && !oe_n_in) ? rd : ~last_q;
endmodule // flash_device_model

// ===== bench/test_flash_host_ctrl.sv
// Self-checking bench for the flash host controller with a device model.
// Assumes the package constants and a 10 MHz clock.
`timescale 1ns/1ps
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int ERR_BIT = 4;
  localparam logic [15:0] MAKER = 16'h005a; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h00c3; // Arbitrary value
  logic clock_in = 0, arst_n_in = 0, req_valid_in = 0, boot_unlock_in = 0;
  logic super_voltage_in = 0, flash_reset_in = 0;
  host_op_e req_op_in = OP_READ;
  logic [19:0] req_addr_in = '0, a, b;
  logic [15:0] req_data_in = '0, dq_in, dq_out, got, d;
  logic req_ready_out, resp_valid_out, resp_timeout_out, ce_n_out, we_n_out, oe_n_out;
  logic dq_oe_out, write_protect_n_out, reset_powerdown_pin_n_out, high_voltage_req_out;
  logic [15:0] resp_data_out;
  logic [19:0] addr_out;
  int err_count = 0, check_count = 0, seed = 75, n;
  localparam logic [15:0] OK = 16'h0001 << READY_BIT;
  localparam logic [15:0] BAD = OK | (16'h0001 << ERR_BIT);

  flash_host_ctrl dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .boot_unlock_in(boot_unlock_in),
    .super_voltage_in(super_voltage_in), .flash_reset_in(flash_reset_in),
    .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
    .resp_timeout_out(resp_timeout_out), .ce_n_out(ce_n_out), .we_n_out(we_n_out),
    .oe_n_out(oe_n_out), .addr_out(addr_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
    .dq_in(dq_in), .write_protect_n_out(write_protect_n_out),
    .reset_powerdown_pin_n_out(reset_powerdown_pin_n_out),
    .high_voltage_req_out(high_voltage_req_out));
  flash_device_model #(.ERR_BIT(ERR_BIT), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    partner_u (.clock_in(clock_in), .ce_n_in(ce_n_out), .we_n_in(we_n_out),
    .oe_n_in(oe_n_out), .addr_in(addr_out), .data_in(dq_out), .drive_in(dq_oe_out),
    .write_protect_n_in(write_protect_n_out),
    .reset_powerdown_pin_n_in(reset_powerdown_pin_n_out),
    .high_voltage_in(high_voltage_req_out), .data_out(dq_in));

  // Clock and hang guard
  initial forever #50 clock_in = ~clock_in;
  initial begin
    #(20000 * 100);
    err_count++;
    give_verdict();
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One request held until taken, then a bounded wait for the answer
  task automatic do_op(input host_op_e op, input logic [19:0] ad, input logic [15:0] dt);
    @(posedge clock_in) #1;
    req_valid_in = 1; req_op_in = op; req_addr_in = ad; req_data_in = dt;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100) begin @(posedge clock_in) #1; n++; end
    if (n >= 100) err_count++;
    @(posedge clock_in) #1;
    req_valid_in = 0;
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 19000) begin @(posedge clock_in) #1; n++; end
    if (n >= 19000) err_count++;
    got = resp_data_out;
    check(16'(resp_timeout_out), 16'h0, "poll limit");
  endtask
  task automatic read_word(input logic [19:0] ad);
    do_op(OP_READ_ARRAY, 20'h0, 16'h0);
    do_op(OP_READ, ad, 16'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clock_in);
    #1 arst_n_in = 1;
    do_op(OP_STATUS, 20'h0, 16'h0); check(got, OK, "status");
    do_op(OP_IDENTIFY, 20'h0, 16'h0); check(got, MAKER, "maker");
    do_op(OP_IDENTIFY, 20'h1, 16'h0); check(got, DEVICE, "device");
    $display("test identify done");
    b = 20'h10000 + 20'($random(seed) & 63);
    for (int i = 0; i < 6; i++) begin
      a = b + 20'(i * 64);
      d = 16'($random(seed));
      do_op(i[0] ? OP_ALT_PROGRAM : OP_PROGRAM, a, d); check(got, OK, "prog");
      read_word(a); check(got, d, "prog read");
    end
    $display("test program done");
    do_op(OP_PROGRAM, 20'h00100, 16'h1234); check(got, BAD, "locked");
    read_word(20'h00100); check(got, 16'hffff, "boot read");
    do_op(OP_CLEAR, 20'h0, 16'h0);
    do_op(OP_STATUS, 20'h0, 16'h0); check(got, OK, "clear");
    boot_unlock_in = 1;
    do_op(OP_PROGRAM, 20'h00101, 16'h5a0f); check(got, OK, "wp unlock");
    read_word(20'h00101); check(got, 16'h5a0f, "wp read");
    boot_unlock_in = 0; super_voltage_in = 1;
    @(posedge clock_in) #1 check(16'(high_voltage_req_out), 16'h1, "hv pin");
    do_op(OP_PROGRAM, 20'h00102, 16'h0ff0); check(got, OK, "hv unlock");
    super_voltage_in = 0;
    $display("test boot lock done");
    do_op(OP_ERASE, b, 16'h0); check(got, OK, "erase");
    read_word(b); check(got, 16'hffff, "erased");
    do_op(OP_ERASE, 20'h0, 16'h0); check(got, BAD, "boot erase");
    read_word(20'h00101); check(got, 16'h5a0f, "boot kept");
    do_op(OP_SUSPEND, 20'h3, 16'h0); check(16'(partner_u.suspended), 16'h1, "susp");
    do_op(OP_RESUME, 20'h5, 16'h0); check(16'(partner_u.suspended), 16'h0, "resume");
    $display("test erase done");
    flash_reset_in = 1;
    repeat (2) @(posedge clock_in);
    #1 check(16'(reset_powerdown_pin_n_out), 16'h0, "rp low");
    check(16'(req_ready_out), 16'h0, "ready low");
    flash_reset_in = 0;
    do_op(OP_STATUS, 20'h0, 16'h0); check(got, OK, "rp status");
    $display("test reset pin done");
    give_verdict();
  end
endmodule // test_flash_host_ctrl

// ===== core/flash_cycle_engine.sv
// Single bus cycle engine: one write strobe or one read strobe per start.
// Assumes flash inputs are synchronous to clock_in.
`timescale 1ns/1ps
module flash_cycle_engine
  import flash_host_pkg::*;
#(parameter int AW = 20, parameter int DW = 16) (
  input  wire logic          clock_in,
  input  wire logic          arst_n_in,
  flash_cycle_if.eng         cyc,
  output logic               ce_n_out,
  output logic               we_n_out,
  output logic               oe_n_out,
  output logic [AW-1:0]      addr_out,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe_out,
  input  wire logic [DW-1:0] dq_in
);
  import flash_host_pkg::*;
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);
  typedef enum logic [1:0] {E_IDLE, E_STROBE, E_RISE} eng_state_e;
  eng_state_e state;
  logic [7:0] count;
  logic       wr;
  // Strobe counter is eight bits wide
  if (STROBE_CYCLES < 1 || STROBE_CYCLES > 256) begin : g_bad_strobe
    $error("flash_cycle_engine: strobe length out of range");
  end

  // ****************************************
  // Strobe sequencing
  // ****************************************
  // Address and data are driven on the same edge as the falling strobe; rising write edge latches
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= E_IDLE;
      count <= 8'h00;
      wr <= 1'b0;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      addr_out <= '0;
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      cyc.rdata <= '0;
      cyc.done <= 1'b0;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        E_IDLE: begin
          if (cyc.start) begin
            wr <= cyc.is_write;
            addr_out <= cyc.addr;
            dq_out <= cyc.wdata;
            dq_oe_out <= cyc.is_write;
            ce_n_out <= 1'b0;
            we_n_out <= !cyc.is_write;
            oe_n_out <= cyc.is_write;
            count <= 8'h00;
            state <= E_STROBE;
          end
        end
        E_STROBE: begin
          if (count == STROBE_LAST) begin
            if (!wr) cyc.rdata <= dq_in;
            we_n_out <= 1'b1; // RQ19
            oe_n_out <= 1'b1;
            state <= E_RISE;
          end else begin
            count <= count + 8'h01;
          end
        end
        E_RISE: begin
          ce_n_out <= 1'b1;
          dq_oe_out <= 1'b0;
          cyc.done <= 1'b1;
          state <= E_IDLE;
        end
        default: state <= E_IDLE;
      endcase
    end
  end
  assign cyc.busy = (state != E_IDLE);

  AST_WE_RISE_UNDER_CE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $rose(we_n_out) |-> !ce_n_out) else $error("write strobe rose without chip enable"); // RQ19
  AST_DONE_AFTER_START: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == E_IDLE) |-> ##[2:300] cyc.done) else $error("cycle never finished");
endmodule // flash_cycle_engine

// ===== core/flash_host_ctrl.sv
// Host controller for a boot-block flash: turns operation requests into
// command write/read cycle sequences, polls status, drives protect pins.
// Assumes one requester, flash bus pins synchronous to clock_in.
// Contract
// RQ1: FFh write returns array read mode
// RQ2: 90h write enters identify mode
// RQ3: Identify read 00h maker, 01h device
// RQ4: 70h write makes next read status
// RQ5: 50h write clears status
// RQ6: Erase is 20h then D0h at block
// RQ7: B0h suspends erase, D0h resumes
// RQ8: Program is 40h then location, value
// RQ9: 10h is alternate program setup
// RQ10: Device verifies and pre-zeroes itself
// RQ11: Boot block locked without unlock
// RQ12: Boot block reads like any other
// RQ13: Super-voltage unlocks boot block
// RQ14: Other blocks need no super-voltage
// RQ15: Protect pin low refuses boot changes
// RQ16: Protect pin high unlocks boot block
// RQ17: Reset pin low clears device state
// RQ18: Status readable during any operation
// RQ19: Writes latch on rising strobe, chip enabled
// RQ20: Poll done before next program/erase
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
#(parameter int AW = 20, parameter int DW = 16) (
  input  wire logic                  clock_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  req_valid_in,
  output logic                       req_ready_out,
  input  wire flash_host_pkg::host_op_e req_op_in,
  input  wire logic [AW-1:0]         req_addr_in,
  input  wire logic [DW-1:0]         req_data_in,
  input  wire logic                  boot_unlock_in,
  input  wire logic                  super_voltage_in,
  input  wire logic                  flash_reset_in,
  output logic                       resp_valid_out,
  output logic [DW-1:0]              resp_data_out,
  output logic                       resp_timeout_out,
  output logic                       ce_n_out,
  output logic                       we_n_out,
  output logic                       oe_n_out,
  output logic [AW-1:0]              addr_out,
  output logic [DW-1:0]              dq_out,
  output logic                       dq_oe_out,
  input  wire logic [DW-1:0]         dq_in,
  output logic                       write_protect_n_out,
  output logic                       reset_powerdown_pin_n_out,
  output logic                       high_voltage_req_out
);
  import flash_host_pkg::*;
  // Ready bit and identify offsets need at least a byte of bus
  if (DW < 8 || AW < 8) begin : g_bad_width
    $error("flash_host_ctrl: AW and DW must be at least 8");
  end
  localparam logic [DW-1:0] POLL_MAX = DW'(POLL_LIMIT);

  typedef enum logic [2:0] {S_IDLE, S_CMD, S_SECOND, S_READ, S_POLL, S_RESP} seq_state_e;
  seq_state_e state;
  host_op_e   op;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;
  logic [DW-1:0] polls;
  logic          timeout;
  flash_cycle_if #(.AW(AW), .DW(DW)) cyc ();

  // ****************************************
  // Cycle engine
  // ****************************************
  flash_cycle_engine #(.AW(AW), .DW(DW)) u_engine (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .cyc       (cyc),
    .ce_n_out  (ce_n_out),
    .we_n_out  (we_n_out),
    .oe_n_out  (oe_n_out),
    .addr_out  (addr_out),
    .dq_out    (dq_out),
    .dq_oe_out (dq_oe_out),
    .dq_in     (dq_in)
  );

  // ****************************************
  // Protect and reset pins
  // ****************************************
  // Pins follow host levels; reset asserts on request and while arst_n_in is low
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      write_protect_n_out <= 1'b0;
      reset_powerdown_pin_n_out <= 1'b0;
      high_voltage_req_out <= 1'b0;
    end else begin
      write_protect_n_out <= boot_unlock_in; // RQ16
      reset_powerdown_pin_n_out <= !flash_reset_in; // RQ17
      high_voltage_req_out <= super_voltage_in && !flash_reset_in; // RQ13
    end
  end

  // ****************************************
  // Command word selection
  // ****************************************
  // First write of each operation except OP_READ, which has no write, carries its command code
  function automatic logic [7:0] first_code(input host_op_e o);
    case (o)
      OP_READ_ARRAY:  first_code = CMD_READ_ARRAY;   // RQ1
      OP_IDENTIFY:    first_code = CMD_IDENTIFY;     // RQ2
      OP_STATUS:      first_code = CMD_READ_STATUS;  // RQ4
      OP_CLEAR:       first_code = CMD_CLEAR_STATUS; // RQ5
      OP_ERASE:       first_code = CMD_ERASE_SETUP;  // RQ6
      OP_SUSPEND:     first_code = CMD_SUSPEND;      // RQ7
      OP_RESUME:      first_code = CMD_CONFIRM;      // RQ7
      OP_PROGRAM:     first_code = CMD_PROG_SETUP;   // RQ8
      OP_ALT_PROGRAM: first_code = CMD_ALT_PROG;     // RQ9
      default:        first_code = CMD_READ_ARRAY;
    endcase
  endfunction

  // Engine request, combinational from sequencer state
  always_comb begin
    cyc.start = 1'b0;
    cyc.is_write = 1'b1;
    cyc.addr = addr;
    cyc.wdata = '0;
    if (!cyc.busy && !cyc.done) begin
      case (state)
        S_CMD: begin
          cyc.start = 1'b1;
          cyc.wdata = DW'(first_code(op));
        end
        S_SECOND: begin
          cyc.start = 1'b1;
          cyc.wdata = (op == OP_ERASE) ? DW'(CMD_CONFIRM) : data; // RQ6 RQ8
        end
        S_READ, S_POLL: begin
          cyc.start = 1'b1;
          cyc.is_write = 1'b0; // RQ18
        end
        default: cyc.start = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  // Program and erase poll until ready, or stop with a timeout on the unready poll that finds polls already at POLL_LIMIT
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= S_IDLE;
      op <= OP_READ;
      addr <= '0;
      data <= '0;
      polls <= '0;
      timeout <= 1'b0;
      resp_data_out <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (req_valid_in && !flash_reset_in) begin
            op <= req_op_in;
            addr <= req_addr_in;
            data <= req_data_in;
            polls <= '0;
            timeout <= 1'b0;
            state <= (req_op_in == OP_READ) ? S_READ : S_CMD;
          end
        end
        S_CMD: begin
          if (cyc.done) begin
            case (op)
              OP_ERASE, OP_PROGRAM, OP_ALT_PROGRAM: state <= S_SECOND;
              OP_STATUS, OP_IDENTIFY: state <= S_READ; // RQ3 RQ4
              default: state <= S_RESP;
            endcase
          end
        end
        S_SECOND: begin
          if (cyc.done) state <= S_POLL; // RQ20
        end
        S_READ: begin
          if (cyc.done) begin
            resp_data_out <= cyc.rdata; // RQ12
            state <= S_RESP;
          end
        end
        S_POLL: begin
          if (cyc.done) begin
            resp_data_out <= cyc.rdata;
            polls <= polls + 1'b1;
            if (cyc.rdata[READY_BIT]) begin
              state <= S_RESP; // RQ20
            end else if (polls == POLL_MAX) begin
              timeout <= 1'b1;
              state <= S_RESP;
            end
          end
        end
        S_RESP: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  assign req_ready_out = (state == S_IDLE) && !flash_reset_in;
  assign resp_valid_out = (state == S_RESP);
  assign resp_timeout_out = (state == S_RESP) && timeout;

  // ****************************************
  // Checks
  // ****************************************
  AST_ERASE_CONFIRM: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == S_SECOND && op == OP_ERASE) |-> cyc.wdata == DW'(8'hd0))
    else $error("erase confirm code wrong"); // RQ6
  AST_PROGRAM_DATA: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == S_SECOND && op == OP_PROGRAM) |-> cyc.wdata == data)
    else $error("program value not sent"); // RQ8
  AST_ALT_CODE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == S_CMD && op == OP_ALT_PROGRAM) |-> cyc.wdata == DW'(8'h10))
    else $error("alternate setup code wrong"); // RQ9
  AST_ARRAY_CODE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == S_CMD && op == OP_READ_ARRAY) |-> cyc.wdata == DW'(8'hff))
    else $error("read array code wrong"); // RQ1
  AST_IDENT_READS: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state == S_CMD && op == OP_IDENTIFY && cyc.done) |=> state == S_READ)
    else $error("identify not followed by read"); // RQ2
  AST_STATUS_READ: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state == S_CMD && op == OP_STATUS && cyc.done) |=> state == S_READ)
    else $error("status command not followed by read"); // RQ4
  AST_CLEAR_CODE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (cyc.start && state == S_CMD && op == OP_CLEAR) |-> cyc.wdata == DW'(8'h50))
    else $error("clear status code wrong"); // RQ5
  AST_POLL_AFTER_WRITE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state == S_SECOND && cyc.done) |=> state == S_POLL)
    else $error("second write not followed by polling"); // RQ20
  AST_UNLOCK_PIN: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    1'b1 |=> write_protect_n_out == $past(boot_unlock_in))
    else $error("protect pin does not follow unlock request"); // RQ16
  AST_RESET_PIN: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    flash_reset_in |=> (!reset_powerdown_pin_n_out && !high_voltage_req_out))
    else $error("reset pin not driven low"); // RQ17
  COV_ERASE: cover property (@(posedge clock_in) disable iff (!arst_n_in)
    state == S_POLL && op == OP_ERASE ##[1:1000] resp_valid_out);
  COV_PROGRAM: cover property (@(posedge clock_in) disable iff (!arst_n_in)
    state == S_POLL && op == OP_PROGRAM ##[1:1000] resp_valid_out);
  COV_IDENTIFY: cover property (@(posedge clock_in) disable iff (!arst_n_in)
    state == S_READ && op == OP_IDENTIFY ##[1:100] resp_valid_out);
endmodule // flash_host_ctrl

// ===== pkg/flash_cycle_if.sv
// Interface between the sequencer and the bus cycle engine.
// Assumes both ends share clock_in.
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int AW = 20, parameter int DW = 16);
  logic          start;
  logic          is_write;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          busy;
  logic          done;
  logic [DW-1:0] rdata;
  modport seq (output start, is_write, addr, wdata, input busy, done, rdata);
  modport eng (input start, is_write, addr, wdata, output busy, done, rdata);
endinterface

// ===== pkg/flash_host_pkg.sv
// Package for the boot-block flash host controller: command codes, identify
// offsets, bus timing counts and the host command enumeration.
// Assumes a 10 MHz system clock and an asynchronous parallel flash bus.
package flash_host_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_IDENTIFY     = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_ALT_PROG     = 8'h10;
  // ****************************************
  // Identify locations and status
  // ****************************************
  localparam logic [7:0] ID_MAKER_LOC     = 8'h00;
  localparam logic [7:0] ID_DEVICE_LOC    = 8'h01;
  localparam int         READY_BIT        = 7;
  // ****************************************
  // Bus timing
  // ****************************************
  localparam int         CLOCK_HZ         = 10_000_000;
  localparam int         STROBE_NS        = 100;
  localparam int         STROBE_CYCLES    = (STROBE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int         POLL_LIMIT       = 4000;
  // ****************************************
  // Host operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_READ, OP_READ_ARRAY, OP_IDENTIFY, OP_STATUS, OP_CLEAR,
    OP_ERASE, OP_SUSPEND, OP_RESUME, OP_PROGRAM, OP_ALT_PROGRAM
  } host_op_e;
endpackage
